// *** core/ccs_regs.sv ***
// Purpose: Video-setting check, software trigger, data depth and brightness registers
// Assumes: Register port is synchronous to sys_clk; video settings from same domain
// Notes:   Reads return data one cycle after the read strobe
`timescale 1ns/100ps
// Function
// R1 - The video-setting check is recomputed whenever format, mode, rate or speed change.
// R2 - The check reads 0 when the combination is acceptable and 1 when it is not.
// R3 - The check is unused in the custom format and ignores writes.
// R4 - Writing bit 0 of the trigger register as 1 sets the trigger, as 0 releases it.
// R5 - The trigger bit only fires exposures when the trigger source selects software.
// R6 - In trigger mode 0 the trigger bit clears itself after being set.
// R7 - The depth register's low byte reports bits per pixel from the pixel format alone; the 16-bit formats read 12, not 16.
// R8 - Brightness bit 0 always reads 1 and ignores writes.
// R9 - Brightness bit 1 always reads 0 and is read only.
// R10 - Brightness bit 5 always reads 0 and is read only.
// R11 - Brightness bit 6 always reads 1 and is read only.
// R12 - Brightness bit 7 always reads 0 and is read only.
// R13 - The brightness value in bits 20 to 31 spans 0 to 255 and resets to 16.
// R14 - In 8-bit and YUV formats every 16 steps of brightness add 1 to each pixel.
// R15 - In 16-bit formats every step of brightness adds 1 to each pixel.
// R16 - Reserved bits read zero and ignore writes.
module ccs_regs (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        reset_n,
   input  wire logic        clkEn,
   // Register port
   input  wire logic        regWrite,
   input  wire logic        regRead,
   input  wire logic [11:0] regAddr,
   input  wire logic [31:0] regWdata,
   output logic [31:0]      regRdata,
   output logic             regRvalid,
   // Current video settings
   input  wire logic [2:0]  videoFormat,
   input  wire logic [2:0]  videoMode,
   input  wire logic [2:0]  frameRate,
   input  wire logic [1:0]  busSpeed,
   input  wire logic [2:0]  pixelFormat,
   // Trigger mode settings
   input  wire logic [3:0]  triggerMode,
   input  wire logic [2:0]  triggerSource,
   // Trigger and capture status
   output logic             softTrigger,
   output logic             softExposeStart,
   output logic             captureAllowed,
   // Pixel stream
   input  wire logic        pixInValid,
   input  wire logic [15:0] pixIn,
   output logic             pixOutValid,
   output logic [15:0]      pixOut
);
   typedef enum logic [1:0] {
      TRG_IDLE = 2'b01,
      TRG_HELD = 2'b10
   } ccs_trig_type;

   logic        rstMeta_n;
   logic        rstSync_n;
   logic        settingError;
   logic [12:0] lastSettings;
   logic [12:0] curSettings;
   logic [11:0] brightValue;
   logic [7:0]  depth;
   logic        trigWrite;
   logic        trigPrev;
   ccs_trig_type trigState;
   ccs_trig_type next_trigState;

   // Combination acceptance, one place for both paths
   function automatic logic combo_bad(input logic [2:0] fmt, input logic [2:0] mode,
                                      input logic [2:0] rate, input logic [1:0] speed);
      combo_bad = (fmt != ccs_pkg::FORMAT_CUSTOM) &&
                  ((mode > ccs_pkg::MODE_MAX) || (rate > ccs_pkg::RATE_MAX) ||
                   (speed > ccs_pkg::SPEED_MAX));
   endfunction

   function automatic logic [7:0] depth_of(input logic [2:0] pix);
      if (pix == ccs_pkg::PIX_MONO16 || pix == ccs_pkg::PIX_RAW16) begin
         depth_of = ccs_pkg::DEPTH_12;
      end else begin
         depth_of = ccs_pkg::DEPTH_8;
      end
   endfunction

   // Reset release through two flops
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rstMeta_n <= 1'b0;
         rstSync_n <= 1'b0;
      end else begin
         rstMeta_n <= 1'b1;
         rstSync_n <= rstMeta_n;
      end
   end

   assign curSettings = {videoFormat, videoMode, frameRate, busSpeed, 2'b00};

   // Re-check only on a setting change; held between changes
   always_ff @(posedge sys_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         lastSettings <= 13'h0000;
         settingError <= 1'b0;
         depth        <= ccs_pkg::DEPTH_8;
      end else if (clkEn) begin
         lastSettings <= curSettings;
         if (curSettings != lastSettings) begin // R1
            if (videoFormat == ccs_pkg::FORMAT_CUSTOM) begin
               settingError <= 1'b0; // R3
            end else begin
               settingError <= combo_bad(videoFormat, videoMode, frameRate, busSpeed); // R2
            end
         end
         depth <= depth_of(pixelFormat); // R7
      end
   end

   assign captureAllowed = !settingError;

   // Brightness value register
   always_ff @(posedge sys_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         brightValue <= ccs_pkg::BRT_VALUE_RESET; // R13
      end else if (clkEn && regWrite && regAddr == ccs_pkg::OFF_BRIGHTNESS) begin
         // Out-of-range values are dropped so the offset stays bounded
         if (regWdata[ccs_pkg::BRT_VALUE_MSB:ccs_pkg::BRT_VALUE_LSB]
             <= ccs_pkg::BRT_VALUE_MAX) begin
            brightValue <= regWdata[ccs_pkg::BRT_VALUE_MSB:ccs_pkg::BRT_VALUE_LSB]; // R13
         end
      end
   end

   assign trigWrite = regWrite && (regAddr == ccs_pkg::OFF_SOFT_TRIGGER);

   always_comb begin
      next_trigState = trigState;
      case (trigState)
         TRG_IDLE: begin
            if (trigWrite && regWdata[ccs_pkg::TRIG_BIT]) begin
               next_trigState = TRG_HELD; // R4
            end
         end
         TRG_HELD: begin
            if (trigWrite && !regWdata[ccs_pkg::TRIG_BIT]) begin
               next_trigState = TRG_IDLE; // R4
            end else if (triggerMode == ccs_pkg::TRIG_MODE_PULSE && !trigWrite) begin
               // A fresh set in the clearing cycle keeps the trigger up
               next_trigState = TRG_IDLE; // R6
            end
         end
         default: next_trigState = TRG_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         trigState <= TRG_IDLE;
         trigPrev  <= 1'b0;
      end else if (clkEn) begin
         trigState <= next_trigState;
         trigPrev  <= (trigState == TRG_HELD);
      end
   end

   assign softTrigger = (trigState == TRG_HELD);
   // Only a rising trigger fires, and only from the software source
   assign softExposeStart = softTrigger && !trigPrev &&
                            (triggerSource == ccs_pkg::TRIG_SRC_SOFT); // R5

   // Read port
   always_ff @(posedge sys_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         regRdata  <= 32'h00000000;
         regRvalid <= 1'b0;
      end else if (clkEn) begin
         regRvalid <= regRead;
         regRdata  <= 32'h00000000; // R16
         if (regRead) begin
            case (regAddr)
               ccs_pkg::OFF_VIDEO_SETTING_ERROR: regRdata[0] <= settingError; // R2
               ccs_pkg::OFF_SOFT_TRIGGER: regRdata[ccs_pkg::TRIG_BIT] <= softTrigger;
               ccs_pkg::OFF_PIXEL_DEPTH: regRdata[7:0] <= depth; // R7
               ccs_pkg::OFF_BRIGHTNESS: begin
                  regRdata[ccs_pkg::BRT_PRESENT_BIT] <= 1'b1; // R8
                  regRdata[ccs_pkg::BRT_ABS_BIT]     <= 1'b0; // R9
                  regRdata[ccs_pkg::BRT_ONEPUSH_BIT] <= 1'b0; // R10
                  regRdata[ccs_pkg::BRT_ENABLE_BIT]  <= 1'b1; // R11
                  regRdata[ccs_pkg::BRT_AUTO_BIT]    <= 1'b0; // R12
                  regRdata[ccs_pkg::BRT_VALUE_MSB:ccs_pkg::BRT_VALUE_LSB] <= brightValue;
               end
               default: regRdata <= 32'h00000000;
            endcase
         end
      end
   end

   ccs_pixel_offset u_offset (
      .sys_clk     (sys_clk),
      .rstSync_n   (rstSync_n),
      .clkEn       (clkEn),
      .pixelFormat (pixelFormat),
      .brightValue (brightValue),
      .pixInValid  (pixInValid),
      .pixIn       (pixIn),
      .pixOutValid (pixOutValid),
      .pixOut      (pixOut)
   ); // R14 R15
endmodule // ccs_regs

// *** inc/ccs_pkg.sv ***
// Purpose: Constants for the camera control and status register slice
// Assumes: Registers addressed by byte offset from the camera base address
// Notes:   Pixel format codes and the acceptance table are local encodings
package ccs_pkg;
   // Register offsets
   localparam logic [11:0] OFF_VIDEO_SETTING_ERROR = 12'h628;
   localparam logic [11:0] OFF_SOFT_TRIGGER        = 12'h62c;
   localparam logic [11:0] OFF_PIXEL_DEPTH         = 12'h630;
   localparam logic [11:0] OFF_BRIGHTNESS          = 12'h800;

   // Brightness field positions
   localparam int BRT_PRESENT_BIT = 0;
   localparam int BRT_ABS_BIT     = 1;
   localparam int BRT_ONEPUSH_BIT = 5;
   localparam int BRT_ENABLE_BIT  = 6;
   localparam int BRT_AUTO_BIT    = 7;
   localparam int BRT_VALUE_LSB   = 20;
   localparam int BRT_VALUE_MSB   = 31;

   // Brightness value limits and reset
   localparam logic [11:0] BRT_VALUE_RESET = 12'h010;
   localparam logic [11:0] BRT_VALUE_MAX   = 12'h0ff;
   localparam int          BRT_STEP_SHIFT8 = 4;

   // Software trigger field
   localparam int TRIG_BIT = 0;

   // Video format codes
   localparam logic [2:0] FORMAT_CUSTOM = 3'h7;

   // Local pixel format codes
   localparam logic [2:0] PIX_MONO8  = 3'h0;
   localparam logic [2:0] PIX_RAW8   = 3'h1;
   localparam logic [2:0] PIX_YUV422 = 3'h2;
   localparam logic [2:0] PIX_MONO16 = 3'h3;
   localparam logic [2:0] PIX_RAW16  = 3'h4;

   // Data depth values
   localparam logic [7:0] DEPTH_8  = 8'h08;
   localparam logic [7:0] DEPTH_12 = 8'h0c;

   // Bus speed, frame rate and video mode code limits
   localparam logic [1:0] SPEED_MAX = 2'h2;
   localparam logic [2:0] RATE_MAX  = 3'h5;
   localparam logic [2:0] MODE_MAX  = 3'h5;

   localparam logic [3:0] TRIG_MODE_PULSE = 4'h0;
   localparam logic [2:0] TRIG_SRC_SOFT   = 3'h7;
endpackage

// *** core/ccs_pixel_offset.sv ***
// Purpose: Adds the brightness offset to each pixel value
// Assumes: Pixel data 16 bits wide, 8-bit formats in the low byte
// Notes:   Result saturates at full scale rather than wrapping
`timescale 1ns/100ps
module ccs_pixel_offset (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rstSync_n,
   input  wire logic        clkEn,
   // Settings
   input  wire logic [2:0]  pixelFormat,
   input  wire logic [11:0] brightValue,
   // Pixel stream
   input  wire logic        pixInValid,
   input  wire logic [15:0] pixIn,
   output logic             pixOutValid,
   output logic [15:0]      pixOut
);
   logic        wide;
   logic [16:0] sum;
   logic [15:0] offset;

   assign wide = (pixelFormat == ccs_pkg::PIX_MONO16) ||
                 (pixelFormat == ccs_pkg::PIX_RAW16);
   always_comb begin
      if (wide) begin
         offset = {4'h0, brightValue}; // R15
      end else begin
         offset = {8'h00, brightValue[11:4]}; // R14
      end
   end
   assign sum = {1'b0, pixIn} + {1'b0, offset};

   always_ff @(posedge sys_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         pixOut      <= 16'h0000;
         pixOutValid <= 1'b0;
      end else if (clkEn) begin
         pixOutValid <= pixInValid;
         if (wide) begin
            pixOut <= sum[16] ? 16'hffff : sum[15:0];
         end else begin
            // Clip 8-bit formats at 255
            pixOut <= (sum[16:8] != 9'h000) ? 16'h00ff : sum[15:0];
         end
      end
   end
endmodule // ccs_pixel_offset

// *** verif/ccs_host_model.sv ***
// Purpose: Host side of the register port
// Assumes: Strobes change at the falling edge
// Notes:   Read answer is fixed at one cycle
`timescale 1ns/100ps
module ccs_host_model (
   // Clock
   input  wire logic        sys_clk,
   // Register port
   output logic             regWrite,
   output logic             regRead,
   output logic [11:0]      regAddr,
   output logic [31:0]      regWdata,
   input  wire logic [31:0] regRdata,
   input  wire logic        regRvalid
);
   initial begin
      regWrite = 1'b0;
      regRead  = 1'b0;
      regAddr  = 12'h000;
      regWdata = 32'h00000000;
   end
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(negedge sys_clk);
      regAddr  = a;
      regWdata = d;
      regWrite = 1'b1;
      @(negedge sys_clk);
      regWrite = 1'b0;
      // Stale data would hide a missed strobe
      regWdata = ~d;
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic ok);
      @(negedge sys_clk);
      regAddr = a;
      regRead = 1'b1;
      @(negedge sys_clk);
      regRead = 1'b0;
      ok      = regRvalid;
      d       = regRdata;
   endtask
endmodule // ccs_host_model

// *** verif/ccs_regs_asserts.sv ***
// Purpose: Port checks for the register slice
// Assumes: Settings held two cycles by the host
// Notes:   Flag lags settings by one cycle
`timescale 1ns/100ps
module ccs_regs_asserts (
   // Clock, reset and register port
   input wire logic        sys_clk,
   input wire logic        reset_n,
   input wire logic        clkEn,
   input wire logic        regWrite,
   input wire logic        regRead,
   input wire logic [11:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic [31:0] regRdata,
   input wire logic        regRvalid,
   // Settings and status
   input wire logic [2:0]  videoFormat,
   input wire logic [2:0]  videoMode,
   input wire logic [2:0]  frameRate,
   input wire logic [1:0]  busSpeed,
   input wire logic [3:0]  triggerMode,
   input wire logic [2:0]  triggerSource,
   input wire logic        softTrigger,
   input wire logic        softExposeStart,
   input wire logic        captureAllowed
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   wire logic trigWr = clkEn && regWrite && regAddr == 12'h62c && regWdata[0];
   wire logic okSet  = videoMode < 3'h6 && frameRate < 3'h6 && busSpeed < 2'h3;
   sequence sStd(logic ok);
      clkEn && videoFormat != 3'h7 && okSet == ok;
   endsequence
   sequence sRd(logic [11:0] a);
      clkEn && regRead && regAddr == a;
   endsequence
   AST_ERR_BAD: assert property (sStd(1'b0) [*2] |-> !captureAllowed)
      else $error("capture allowed for bad setting");
   AST_ERR_OK: assert property (sStd(1'b1) [*2] |-> captureAllowed)
      else $error("capture blocked for good setting");
   AST_ERR_CUSTOM: assert property ((clkEn && videoFormat == 3'h7) [*2] |-> captureAllowed)
      else $error("flag set in custom format");
   AST_TRIG_SET: assert property (trigWr |=> softTrigger)
      else $error("trigger not set");
   AST_TRIG_PULSE: assert property (
      clkEn && softTrigger && triggerMode == 4'h0 && !trigWr |=> !softTrigger)
      else $error("trigger did not self clear");
   AST_EXPOSE: assert property (softExposeStart |-> $rose(softTrigger) && triggerSource == 3'h7)
      else $error("exposure without soft source");
   AST_BRT_FIXED: assert property (sRd(12'h800) |=> regRvalid && regRdata[19:0] == 20'h00041)
      else $error("brightness fixed bits wrong");
   AST_UNMAPPED: assert property (sRd(12'h634) |=> regRvalid && regRdata == 32'h0)
      else $error("unmapped read not zero");
endmodule // ccs_regs_asserts
bind ccs_regs ccs_regs_asserts i_ccs_regs_asserts (
   .sys_clk(sys_clk), .reset_n(reset_n), .clkEn(clkEn), .regWrite(regWrite),
   .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
   .regRvalid(regRvalid), .videoFormat(videoFormat), .videoMode(videoMode),
   .frameRate(frameRate), .busSpeed(busSpeed), .triggerMode(triggerMode),
   .triggerSource(triggerSource), .softTrigger(softTrigger),
   .softExposeStart(softExposeStart), .captureAllowed(captureAllowed));

// *** verif/tb_top.sv ***
// Purpose: Self-checking bench for the register slice
// Assumes: Host model owns the register port
// Notes:   Random values from a 16-bit shift register
`timescale 1ns/100ps
module tb_top;
   logic        sys_clk = 1'b0, reset_n = 1'b0, clkEn = 1'b1, pixInValid = 1'b0;
   logic        regWrite, regRead, regRvalid, ok, softTrigger, softExposeStart;
   logic        captureAllowed, pixOutValid;
   logic [2:0]  videoFormat = 3'h0, videoMode = 3'h0, frameRate = 3'h0;
   logic [2:0]  pixelFormat = 3'h0, triggerSource = 3'h7;
   logic [1:0]  busSpeed = 2'h0;
   logic [3:0]  triggerMode = 4'h0;
   logic [11:0] regAddr, v;
   logic [31:0] regWdata, regRdata, rdat;
   logic [15:0] pixIn = 16'h0000, pixOut, rnd = 16'hdef0;
   int          fails = 0, n_checks = 0;
   always #4 sys_clk = ~sys_clk;
   ccs_regs i_ccs_regs (
      .sys_clk(sys_clk), .reset_n(reset_n), .clkEn(clkEn), .regWrite(regWrite),
      .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
      .regRvalid(regRvalid), .videoFormat(videoFormat), .videoMode(videoMode),
      .frameRate(frameRate), .busSpeed(busSpeed), .pixelFormat(pixelFormat),
      .triggerMode(triggerMode), .triggerSource(triggerSource), .softTrigger(softTrigger),
      .softExposeStart(softExposeStart), .captureAllowed(captureAllowed),
      .pixInValid(pixInValid), .pixIn(pixIn), .pixOutValid(pixOutValid), .pixOut(pixOut));
   ccs_host_model i_ccs_host_model (
      .sys_clk(sys_clk), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
      .regWdata(regWdata), .regRdata(regRdata), .regRvalid(regRvalid));
   function automatic logic [15:0] nextRand(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic expFlag();
      return videoFormat != 3'h7 && (videoMode > 3'h5 || frameRate > 3'h5 || busSpeed > 2'h2);
   endfunction
   function automatic logic [15:0] expPix();
      logic [16:0] sum;
      if (pixelFormat > 3'h2) sum = {1'b0, pixIn} + {5'h00, v};
      else sum = {9'h000, pixIn[7:0]} + {9'h000, v[11:4]};
      // Clip rather than wrap at full scale
      if (pixelFormat < 3'h3 && sum > 17'h000ff) sum = 17'h000ff;
      if (sum > 17'h0ffff) sum = 17'h0ffff;
      return sum[15:0];
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic rdChk(input logic [11:0] a, input logic [31:0] exp);
      i_ccs_host_model.rd(a, rdat, ok);
      chk({31'h0, ok}, 32'h1);
      chk(rdat, exp);
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge sys_clk);
      fails++;
      test_done();
   end
   initial begin
      repeat (2) @(negedge sys_clk);
      reset_n = 1'b1;
      repeat (3) @(negedge sys_clk);
      rdChk(12'h800, 32'h01000041);
      rdChk(12'h62c, 32'h0);
      rdChk(12'h634, 32'h0);
      for (int i = 0; i < 6; i++) begin
         rnd = nextRand(rnd);
         // Host keeps the value within 0 to 255
         v = (i == 0) ? 12'h0ff : (i == 1) ? 12'h000 : {4'h0, rnd[7:0]};
         i_ccs_host_model.wr(12'h800, {v, 20'hfffff});
         i_ccs_host_model.wr(12'h800, {12'h100, 20'h00000});
         rdChk(12'h800, {v, 20'h00041});
         for (int f = 0; f < 5; f++) begin
            pixelFormat = f[2:0];
            pixIn = (i == 0) ? 16'hffff : nextRand(rnd + f[15:0]);
            if (f < 3) pixIn[15:8] = 8'h00;
            pixInValid = 1'b1;
            @(negedge sys_clk);
            pixInValid = 1'b0;
            chk({31'h0, pixOutValid}, 32'h1);
            chk({16'h0, pixOut}, {16'h0, expPix()});
            rdChk(12'h630, (f > 2) ? 32'h0c : 32'h08);
         end
      end
      for (int i = 0; i < 24; i++) begin
         rnd = nextRand(rnd);
         {videoFormat, videoMode, frameRate, busSpeed} = (i < 2) ? 11'h7ff : rnd[10:0];
         repeat (2) @(negedge sys_clk);
         chk({31'h0, captureAllowed}, {31'h0, ~expFlag()});
         if (i % 6 == 0) begin
            i_ccs_host_model.wr(12'h628, 32'hffffffff);
            rdChk(12'h628, {31'h0, expFlag()});
         end
      end
      {videoFormat, videoMode, frameRate, busSpeed} = 11'h000;
      for (int i = 0; i < 4; i++) begin
         triggerMode = {3'h0, i[0]};
         triggerSource = i[1] ? 3'h7 : 3'h3;
         i_ccs_host_model.wr(12'h62c, 32'hffffffff);
         chk({31'h0, softTrigger}, 32'h1);
         chk({31'h0, softExposeStart}, {31'h0, i[1]});
         @(negedge sys_clk);
         chk({31'h0, softTrigger}, {31'h0, i[0]});
         rdChk(12'h62c, {31'h0, i[0]});
         i_ccs_host_model.wr(12'h62c, 32'hfffffffe);
         chk({31'h0, softTrigger}, 32'h0);
      end
      // Mid-run reset must restore the brightness default
      i_ccs_host_model.wr(12'h800, {12'h0a0, 20'h00000});
      reset_n = 1'b0;
      repeat (2) @(negedge sys_clk);
      reset_n = 1'b1;
      repeat (3) @(negedge sys_clk);
      // Frozen clock enable: neither the write nor the read may land
      clkEn = 1'b0;
      i_ccs_host_model.wr(12'h800, {12'h020, 20'h00000});
      i_ccs_host_model.rd(12'h800, rdat, ok);
      chk({31'h0, ok}, 32'h0);
      clkEn = 1'b1;
      rdChk(12'h800, 32'h01000041);
      test_done();
   end
endmodule // tb_top
